// ==== pmsc_mode_top.sv ====
/*
 Strap and status logic of a 10/100 PHY: configuration source,
 speed, duplex, auto-negotiation, MAC interface variant, carrier
 sense, collision, lock and link status.
 Assumes straps synchronous to clk and held steady in operation.
*/
// Operation
// - Source select low means hardware straps, high means software registers.
// - Hardware mode: speed pin input, low 10M, high 100M.
// - Software mode: speed pin driven with current speed selection.
// - Hardware mode: autoneg pin input, high enables auto-negotiation.
// - Software mode: autoneg pin driven high when auto-negotiation enabled.
// - Hardware mode: duplex pin input, low half, high full.
// - Software mode: duplex pin driven high for full duplex.
// - Interface select low gives MII, high gives stream interface.
// - Stream variant select ignored unless 10M and stream both selected.
// - Variant low selects 10M serial, high selects link pulse.
// - Lock output high while descrambler holds lock, else low.
// - Link status output high while link established, else low.
// - Link output is signal detect for symbol and link pulse modes.
// - Node/repeater select sets role, changing SQE test and carrier sense.
// - Repeater or full duplex: carrier sense only for receive activity.
// - Collision asserted during SQE test in half-duplex node mode unless SQE inhibit bit set.
// - Device held in reset while active-low reset input is low.
`timescale 1ns/1ps
`default_nettype none

`include "pmsc_cfg.svh"

module pmsc_mode_top
	import pmsc_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           rst,
	input  wire logic           resetIn_n,
	input  wire logic           configSourceSelect,
	input  wire logic           interfaceSelect,
	input  wire logic           streamVariantSelect,
	input  wire logic           nodeRepeaterSelect,
	input  wire logic           speedSelectIn,
	output logic                speedSelectOut,
	output logic                speedSelectOe,
	input  wire logic           autonegSelectIn,
	output logic                autonegSelectOut,
	output logic                autonegSelectOe,
	input  wire logic           duplexSelectIn,
	output logic                duplexSelectOut,
	output logic                duplexSelectOe,
	input  wire pmsc_opmode_t   regMode,
	input  wire logic           sqeInhibit,
	input  wire pmsc_activity_t activity,
	input  wire logic           collisionDetect,
	input  wire logic           descramblerLocked,
	input  wire logic           linkUp,
	input  wire logic           signalDetectRaw,
	output logic                lockOut,
	output logic                linkStatusOut,
	output logic                carrierSense,
	output logic                collision,
	output pmsc_ifmode_t        ifMode,
	output logic                repeaterMode,
	output pmsc_opmode_t        opMode,
	output logic                inReset
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic         lock;
		logic         link;
		logic         crs;
		logic         col;
		pmsc_ifmode_t ifm;
		logic         rep;
		logic         hold;
	} pmsc_top_st_t;

	pmsc_top_st_t st_q;
	pmsc_top_st_t st_d;
	logic         swMode;
	logic         devRst;
	logic         effSpeed;
	logic         effDuplex;
	logic         effAutoneg;
	pmsc_opmode_t eff;

	assign devRst = rst | ~resetIn_n;
	assign swMode = (configSourceSelect == `PMSC_SRC_SW);

	// ---------------------------------------------------------------
	// Strap pins
	// ---------------------------------------------------------------
	// speed pin
	pmsc_pin_mux uSpeed (
		.clk    (clk),
		.rst    (devRst),
		.swMode (swMode),
		.pinIn  (speedSelectIn),
		.regVal (regMode.speed),
		.rstVal (`PMSC_RST_SPEED),
		.pinOut (speedSelectOut),
		.pinOe  (speedSelectOe),
		.eff    (effSpeed)
	);

	pmsc_pin_mux uDuplex (
		.clk    (clk),
		.rst    (devRst),
		.swMode (swMode),
		.pinIn  (duplexSelectIn),
		.regVal (regMode.duplex),
		.rstVal (`PMSC_RST_DUPLEX),
		.pinOut (duplexSelectOut),
		.pinOe  (duplexSelectOe),
		.eff    (effDuplex)
	);

	pmsc_pin_mux uAutoneg (
		.clk    (clk),
		.rst    (devRst),
		.swMode (swMode),
		.pinIn  (autonegSelectIn),
		.regVal (regMode.autoneg),
		.rstVal (`PMSC_RST_AUTONEG),
		.pinOut (autonegSelectOut),
		.pinOe  (autonegSelectOe),
		.eff    (effAutoneg)
	);

	assign eff    = '{speed: effSpeed, duplex: effDuplex, autoneg: effAutoneg};
	assign opMode = eff;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_d      = st_q;
		st_d.hold = 1'h0;
		if (interfaceSelect == `PMSC_IF_MII) begin
			st_d.ifm = PMSC_IF_MII_E;
		end else if (eff.speed == `PMSC_SPEED_100) begin
			st_d.ifm = PMSC_IF_SYMBOL_E;
		end else if (streamVariantSelect == `PMSC_VAR_PULSE) begin
			st_d.ifm = PMSC_IF_PULSE_E;
		end else begin
			st_d.ifm = PMSC_IF_SERIAL_E;
		end
		st_d.rep  = (nodeRepeaterSelect == `PMSC_ROLE_REP);
		st_d.lock = descramblerLocked;
		case (st_d.ifm)
			PMSC_IF_SYMBOL_E,
			PMSC_IF_PULSE_E: st_d.link = signalDetectRaw;
			PMSC_IF_MII_E,
			PMSC_IF_SERIAL_E: st_d.link = linkUp;
			default: st_d.link = 1'h0;
		endcase
		if (st_d.rep || eff.duplex) begin
			st_d.crs = activity.rxActive;
		end else begin
			st_d.crs = activity.rxActive | activity.txActive;
		end
		if (eff.duplex) begin
			st_d.col = 1'h0;
		end else begin
			st_d.col = (collisionDetect & activity.txActive)
				| (activity.sqeTest & ~sqeInhibit & ~st_d.rep);
		end
	end

	always_ff @(posedge clk) begin
		if (devRst) begin
			st_q <= '{lock: 1'h0, link: 1'h0, crs: 1'h0, col: 1'h0,
				ifm: PMSC_IF_MII_E, rep: 1'h0, hold: 1'h1};
		end else begin
			st_q <= st_d;
		end
	end

	assign lockOut       = st_q.lock;
	assign linkStatusOut = st_q.link;
	assign carrierSense  = st_q.crs;
	assign collision     = st_q.col;
	assign ifMode        = st_q.ifm;
	assign repeaterMode  = st_q.rep;
	assign inReset       = st_q.hold;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	// enables follow source
	AST_SRC: assert property (@(posedge clk) disable iff (devRst || inReset)
		1'h1 |=> {speedSelectOe, duplexSelectOe, autonegSelectOe}
		== {3{$past(swMode)}})
		else $error("pin direction does not follow source select");

	AST_HW_SPEED: assert property (@(posedge clk) disable iff (devRst || inReset)
		!swMode |=> !speedSelectOe && !speedSelectOut
		&& opMode.speed == $past(speedSelectIn))
		else $error("speed strap not taken");

	AST_SW_SPEED: assert property (@(posedge clk) disable iff (devRst || inReset)
		swMode ##1 swMode |=> speedSelectOe && speedSelectOut == $past(regMode.speed))
		else $error("speed pin not driven from register");

	AST_HW_AN: assert property (@(posedge clk) disable iff (devRst || inReset)
		!swMode |=> !autonegSelectOe && !autonegSelectOut
		&& opMode.autoneg == $past(autonegSelectIn))
		else $error("autoneg strap not taken");

	AST_SW_AN: assert property (@(posedge clk) disable iff (devRst || inReset)
		swMode |=> autonegSelectOe && autonegSelectOut == $past(regMode.autoneg))
		else $error("autoneg pin wrong");

	AST_HW_DUPLEX: assert property (@(posedge clk) disable iff (devRst || inReset)
		!swMode |=> !duplexSelectOe && opMode.duplex == $past(duplexSelectIn))
		else $error("duplex strap not taken");

	AST_SW_DUPLEX: assert property (@(posedge clk) disable iff (devRst || inReset)
		swMode |=> duplexSelectOe && duplexSelectOut == $past(regMode.duplex))
		else $error("duplex pin not driven from register");

	AST_SW_FOLLOW: assert property (@(posedge clk) disable iff (devRst || inReset)
		swMode |=> opMode == $past(regMode))
		else $error("mode does not follow register settings");

	// ---------------------------------------------------------------
	// Status checks
	// ---------------------------------------------------------------
	// MII selected
	AST_MII: assert property (@(posedge clk) disable iff (devRst || inReset)
		interfaceSelect == `PMSC_IF_MII |=> ifMode == PMSC_IF_MII_E)
		else $error("MII not selected");

	AST_STREAM: assert property (@(posedge clk) disable iff (devRst || inReset)
		interfaceSelect == `PMSC_IF_STREAM |=> ifMode != PMSC_IF_MII_E)
		else $error("stream interface not selected");

	AST_SYMBOL: assert property (@(posedge clk) disable iff (devRst || inReset)
		interfaceSelect && opMode.speed |=> ifMode == PMSC_IF_SYMBOL_E)
		else $error("symbol interface not selected");

	AST_VARIANT: assert property (@(posedge clk) disable iff (devRst || inReset)
		interfaceSelect && !opMode.speed && !streamVariantSelect
		|=> ifMode == PMSC_IF_SERIAL_E)
		else $error("serial variant not selected");

	AST_PULSE: assert property (@(posedge clk) disable iff (devRst || inReset)
		interfaceSelect && !opMode.speed && streamVariantSelect
		|=> ifMode == PMSC_IF_PULSE_E)
		else $error("link pulse variant not selected");

	AST_LOCK: assert property (@(posedge clk) disable iff (devRst || inReset)
		descramblerLocked |=> lockOut)
		else $error("lock not reported");

	AST_LOCK_LOW: assert property (@(posedge clk) disable iff (devRst || inReset)
		!descramblerLocked |=> !lockOut)
		else $error("lock reported without lock");

	AST_LINK_STA: assert property (@(posedge clk) disable iff (devRst || inReset)
		!inReset && (ifMode == PMSC_IF_MII_E || ifMode == PMSC_IF_SERIAL_E)
		|-> linkStatusOut == $past(linkUp))
		else $error("link status not mapped");

	AST_LINK: assert property (@(posedge clk) disable iff (devRst || inReset)
		ifMode == PMSC_IF_SYMBOL_E ##0 $stable(ifMode)
		|-> linkStatusOut == $past(signalDetectRaw))
		else $error("signal detect not mapped");

	AST_ROLE: assert property (@(posedge clk) disable iff (devRst || inReset)
		1'h1 |=> repeaterMode == $past(nodeRepeaterSelect))
		else $error("role does not follow select");

	AST_CRS: assert property (@(posedge clk) disable iff (devRst || inReset)
		(nodeRepeaterSelect || opMode.duplex) && !activity.rxActive |=> !carrierSense)
		else $error("carrier sense on transmit");

	AST_CRS_HALF: assert property (@(posedge clk) disable iff (devRst || inReset)
		!nodeRepeaterSelect && !opMode.duplex && activity.txActive |=> carrierSense)
		else $error("carrier sense missing on transmit");

	AST_SQE: assert property (@(posedge clk) disable iff (devRst || inReset)
		sqeInhibit && !collisionDetect |=> !collision)
		else $error("collision despite SQE inhibit");

	AST_SQE_COL: assert property (@(posedge clk) disable iff (devRst || inReset)
		activity.sqeTest && !sqeInhibit && !nodeRepeaterSelect && !opMode.duplex
		|=> collision)
		else $error("no collision during SQE test");

	AST_FDX_COL: assert property (@(posedge clk) disable iff (devRst || inReset)
		opMode.duplex |=> !collision)
		else $error("collision in full duplex");

	AST_RESET: assert property (@(posedge clk)
		!resetIn_n |=> inReset && !collision && !speedSelectOe)
		else $error("not held in reset");

endmodule // pmsc_mode_top

`default_nettype wire

// ==== pmsc_cfg.svh ====
/*
 Constants for the PHY mode strap and status block.
 Assumes inclusion by bare name from the package and modules.
*/
`ifndef PMSC_CFG_SVH
`define PMSC_CFG_SVH

// ---------------------------------------------------------------
// Strap encodings
// ---------------------------------------------------------------
`define PMSC_SRC_HW        1'h0
`define PMSC_SRC_SW        1'h1
`define PMSC_SPEED_10      1'h0
`define PMSC_SPEED_100     1'h1
`define PMSC_IF_MII        1'h0
`define PMSC_IF_STREAM     1'h1
`define PMSC_VAR_SERIAL    1'h0
`define PMSC_VAR_PULSE     1'h1
`define PMSC_ROLE_NODE     1'h0
`define PMSC_ROLE_REP      1'h1

// ---------------------------------------------------------------
// Reset values of the latched configuration
// ---------------------------------------------------------------
`define PMSC_RST_SPEED     1'h0
`define PMSC_RST_DUPLEX    1'h0
`define PMSC_RST_AUTONEG   1'h0

`endif

// ==== pmsc_pkg.sv ====
/*
 Types for the PHY mode strap and status block.
 Assumes nothing beyond the constants header.
*/
`include "pmsc_cfg.svh"

package pmsc_pkg;

	typedef enum logic [1:0] {
		PMSC_IF_MII_E,
		PMSC_IF_SYMBOL_E,
		PMSC_IF_SERIAL_E,
		PMSC_IF_PULSE_E
	} pmsc_ifmode_t;

	typedef struct packed {
		logic speed;
		logic duplex;
		logic autoneg;
	} pmsc_opmode_t;

	typedef struct packed {
		logic txActive;
		logic rxActive;
		logic sqeTest;
	} pmsc_activity_t;

endpackage : pmsc_pkg

// ==== pmsc_pin_mux.sv ====
/*
 One strap pin that is an input in hardware mode and an output
 in software mode. Assumes synchronous pin inputs.
*/
`timescale 1ns/1ps
`default_nettype none

module pmsc_pin_mux
	import pmsc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic swMode,
	input  wire logic pinIn,
	input  wire logic regVal,
	input  wire logic rstVal,
	output logic      pinOut,
	output logic      pinOe,
	output logic      eff
);

	typedef struct packed {
		logic out;
		logic oe;
		logic eff;
	} pmsc_pin_st_t;

	pmsc_pin_st_t st_q;
	pmsc_pin_st_t st_d;

	always_comb begin
		st_d     = st_q;
		st_d.oe  = swMode;
		st_d.out = swMode ? regVal : 1'h0;
		st_d.eff = swMode ? regVal : pinIn;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '{out: 1'h0, oe: 1'h0, eff: rstVal};
		end else begin
			st_q <= st_d;
		end
	end

	assign pinOut = st_q.out;
	assign pinOe  = st_q.oe;
	assign eff    = st_q.eff;

	AST_PIN_DIR: assert property (@(posedge clk) disable iff (rst)
		$past(rst) == 1'h0 |-> pinOe == $past(swMode))
		else $error("pin direction does not follow mode");

endmodule // pmsc_pin_mux

`default_nettype wire

// ==== pmsc_board_model.sv ====
/*
 Board strapping and MAC-side model for the PHY mode strap block.
 Assumes the device pin outputs and enables of the strap block.
*/
`timescale 1ns/1ps
`default_nettype none

module pmsc_board_model
	import pmsc_pkg::*;
(
	input  wire pmsc_opmode_t strap,
	input  wire logic         speedOut,
	input  wire logic         speedOe,
	input  wire logic         duplexOut,
	input  wire logic         duplexOe,
	input  wire logic         autonegOut,
	input  wire logic         autonegOe,
	output logic              speedPin,
	output logic              duplexPin,
	output logic              autonegPin
);
	// ---------------------------------------------------------------
	// Pin levels
	// ---------------------------------------------------------------
	// straps always defined
	assign speedPin   = speedOe ? speedOut : strap.speed;
	assign duplexPin  = duplexOe ? duplexOut : strap.duplex;
	assign autonegPin = autonegOe ? autonegOut : strap.autoneg;
endmodule // pmsc_board_model

`default_nettype wire

// ==== pmsc_mode_top_test.sv ====
/*
 Self-checking testbench for the PHY mode strap block.
 Assumes the board model resolves the three strap pins.
*/
`timescale 1ns/1ps
`default_nettype none

module pmsc_mode_top_test
	import pmsc_pkg::*;
;
	logic clk = 1'h0, rst = 1'h1, resetIn_n = 1'h1, cfgSrc = 1'h0, ifSel = 1'h0;
	logic varSel = 1'h0, nodeRep = 1'h0, sqeInhibit = 1'h0, collDet = 1'h0;
	logic locked = 1'h0, linkUp = 1'h0, sdRaw = 1'h0;
	pmsc_opmode_t regMode = '0, strap = '0, opMode;
	pmsc_activity_t activity = '0;
	pmsc_ifmode_t ifMode;
	logic spdO, spdE, dpxO, dpxE, anO, anE, spdP, dpxP, anP;
	logic lockOut, linkOut, crs, col, repMode, inReset;
	int bad_count = 0, num_checks = 0;

	always #4 clk = ~clk;

	pmsc_board_model u_board (.strap(strap), .speedOut(spdO), .speedOe(spdE),
		.duplexOut(dpxO), .duplexOe(dpxE), .autonegOut(anO), .autonegOe(anE),
		.speedPin(spdP), .duplexPin(dpxP), .autonegPin(anP));

	pmsc_mode_top u_dut (.clk(clk), .rst(rst), .resetIn_n(resetIn_n),
		.configSourceSelect(cfgSrc), .interfaceSelect(ifSel),
		.streamVariantSelect(varSel), .nodeRepeaterSelect(nodeRep),
		.speedSelectIn(spdP), .speedSelectOut(spdO), .speedSelectOe(spdE),
		.autonegSelectIn(anP), .autonegSelectOut(anO), .autonegSelectOe(anE),
		.duplexSelectIn(dpxP), .duplexSelectOut(dpxO), .duplexSelectOe(dpxE),
		.regMode(regMode), .sqeInhibit(sqeInhibit), .activity(activity),
		.collisionDetect(collDet), .descramblerLocked(locked), .linkUp(linkUp),
		.signalDetectRaw(sdRaw), .lockOut(lockOut), .linkStatusOut(linkOut),
		.carrierSense(crs), .collision(col), .ifMode(ifMode),
		.repeaterMode(repMode), .opMode(opMode), .inReset(inReset));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_modes();
		logic [2:0] inv;
		for (int i = 0; i < 16; i++) begin
			inv = ~i[2:0];
			@(posedge clk);
			cfgSrc <= i[3];
			strap <= i[2:0];
			regMode <= inv;
			settle(3);
			chk({1'h0, spdE, dpxE, anE}, {1'h0, {3{i[3]}}}, "pin enables");
			chk(opMode, i[3] ? inv : i[2:0], "effective mode");
			if (i[3]) begin
				chk({spdO, dpxO, anO}, inv, "driven pins");
			end else begin
				chk({spdO, dpxO, anO}, 3'h0, "idle pins");
			end
		end
	endtask

	task automatic t_iface();
		pmsc_ifmode_t e;
		for (int i = 0; i < 64; i++) begin
			@(posedge clk);
			cfgSrc <= 1'h0;
			{ifSel, strap.speed, varSel, linkUp, sdRaw, locked} <= i[5:0];
			settle(3);
			e = !i[5] ? PMSC_IF_MII_E : i[4] ? PMSC_IF_SYMBOL_E :
				i[3] ? PMSC_IF_PULSE_E : PMSC_IF_SERIAL_E;
			chk(ifMode, e, "interface");
			chk(lockOut, i[0], "lock");
			chk(linkOut, (e == PMSC_IF_SYMBOL_E || e == PMSC_IF_PULSE_E) ? i[1] : i[2],
				"link");
		end
	endtask

	task automatic t_carrier();
		for (int i = 0; i < 128; i++) begin
			@(posedge clk);
			{strap.duplex, nodeRep, activity, sqeInhibit, collDet} <= i[6:0];
			settle(3);
			chk(repMode, i[5], "role");
			chk(crs, i[3] | (i[4] & ~i[6] & ~i[5]), "carrier sense");
			chk(col, ~i[6] & ((i[0] & i[4]) | (i[2] & ~i[1] & ~i[5])), "collision");
		end
	endtask

	task automatic t_reset();
		@(posedge clk);
		cfgSrc <= 1'h1;
		regMode <= 3'h7;
		locked <= 1'h1;
		resetIn_n <= 1'h0;
		settle(2);
		chk({inReset, lockOut, spdE, spdO}, 4'h8, "held in reset");
		chk(ifMode, PMSC_IF_MII_E, "reset interface");
		@(posedge clk);
		resetIn_n <= 1'h1;
		settle(3);
		chk({inReset, lockOut, spdE, spdO}, 4'h7, "after reset");
	endtask

	initial begin
		#100000;
		bad_count++;
		$display("CHECK FAILED t=%0t run timed out", $time);
		summarize();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		t_modes();
		t_iface();
		t_carrier();
		t_reset();
		summarize();
	end
endmodule // pmsc_mode_top_test

`default_nettype wire
